// ### dlcs_params.svh
// Purpose: named offsets, fields, reset values and times of the link register bank
// Assumes: 20 MHz system clock
// Notes: definitions only
`ifndef DLCS_PARAMS_SVH
`define DLCS_PARAMS_SVH

// register offsets
`define DLCS_OFS_CTRL 16'h0100
`define DLCS_OFS_RWOFS 16'h0108
`define DLCS_OFS_STAT 16'h0110

// link control fields
`define DLCS_CTRL_TEMP 1
`define DLCS_CTRL_LOOP_LO 8
`define DLCS_CTRL_LOOP_HI 15
`define DLCS_CTRL_FIFO_LO 16
`define DLCS_CTRL_FIFO_HI 18
`define DLCS_CTRL_JITTER 19
`define DLCS_CTRL_LDTIME 22
`define DLCS_CTRL_ALIAS 24
`define DLCS_CTRL_WMASK 32'h014FFF02

// reset values and delay-reduce limit
`define DLCS_FIFO_DEFAULT 3'h7
`define DLCS_FIFO_REDUCE_MAX 3'h3
`define DLCS_LOOP_RESET 8'h00

// status fields
`define DLCS_STAT_OPER 0
`define DLCS_STAT_WD 1
`define DLCS_STAT_ENH 2
`define DLCS_STAT_LINK_LO 4
`define DLCS_STAT_PORT_LO 8

// times
`define DLCS_CLK_HZ 20000000
`define DLCS_LD_LONG_MS 660
`define DLCS_LD_SHORT_US 80
`define DLCS_TEMP_MS 1000

`endif

// ### dlcs_pkg.sv
// Purpose: shared types of the link register bank
// Assumes: nothing
// Notes: loop mode codes match the two-bit control field
package dlcs_pkg;
	typedef enum logic [1:0] {
		DLCS_LOOP_AUTO = 2'b00,
		DLCS_LOOP_AUTO_CLOSE = 2'b01,
		DLCS_LOOP_OPEN = 2'b10,
		DLCS_LOOP_CLOSED = 2'b11
	} dlcs_loop_mode_t;

	typedef enum logic [0:0] {
		DLCS_TMP_IDLE = 1'b0,
		DLCS_TMP_ACTIVE = 1'b1
	} dlcs_tmp_state_t;
endpackage : dlcs_pkg

// ### dlcs_loop_if.sv
// Purpose: carrier between the register bank and one port loop controller
// Assumes: single clock
// Notes: one instance per port
`timescale 1ns/1ps
`default_nettype none
interface dlcs_loop_if;
	import dlcs_pkg::*;
	dlcs_loop_mode_t mode;
	logic mode_wr;
	logic link;
	logic frame_busy;
	logic valid_frame;
	logic closed;
	modport bank (output mode, output mode_wr, output link, output frame_busy,
		output valid_frame, input closed);
	modport port (input mode, input mode_wr, input link, input frame_busy,
		input valid_frame, output closed);
endinterface : dlcs_loop_if
`default_nettype wire

// ### dlcs_loop_port.sv
// Purpose: loop open/closed decision of one port
// Assumes: frame_busy high while a frame is received or sent on the port
// Notes: new settings wait for the end of the current frame
`timescale 1ns/1ps
`default_nettype none
module dlcs_loop_port
	import dlcs_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// bank side
	dlcs_loop_if.port lp
);
	dlcs_loop_mode_t mode_reg, mode_next;
	logic closed_reg, closed_next;
	logic rearm_reg, rearm_next;

	always_comb begin
		mode_next = mode_reg;
		closed_next = closed_reg;
		rearm_next = rearm_reg | lp.mode_wr;
		if (!lp.frame_busy) begin
			mode_next = lp.mode;
			case (mode_reg)
				DLCS_LOOP_AUTO: begin
					closed_next = !lp.link;
				end
				DLCS_LOOP_AUTO_CLOSE: begin
					if (!lp.link) begin
						closed_next = 1'b1;
					end else if (rearm_reg || lp.valid_frame) begin
						closed_next = 1'b0;
					end
				end
				DLCS_LOOP_OPEN: begin
					closed_next = 1'b0;
				end
				DLCS_LOOP_CLOSED: begin
					closed_next = 1'b1;
				end
				default: begin
					closed_next = 1'b1;
				end
			endcase
			rearm_next = lp.mode_wr;
		end
		// a rewrite made while the link is down is dropped
		if (!lp.link) begin
			rearm_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_reg <= DLCS_LOOP_AUTO;
			closed_reg <= 1'b1;
			rearm_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			closed_reg <= closed_next;
			rearm_reg <= rearm_next;
		end
	end

	assign lp.closed = closed_reg;
endmodule : dlcs_loop_port
`default_nettype wire

// ### dlcs_regs.sv
// Purpose: link-layer control, read/write offset and status registers
// Assumes: network side writes, host interface only reads; reads answer next cycle
// Notes: long timer counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
`include "dlcs_params.svh"
module dlcs_regs
	import dlcs_pkg::*;
#(
	parameter int unsigned LD_LONG_CYC = `DLCS_LD_LONG_MS * (`DLCS_CLK_HZ / 1000),
	parameter int unsigned TEMP_CYC = `DLCS_TEMP_MS * (`DLCS_CLK_HZ / 1000)
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// network side register port
	input wire logic [15:0] net_addr,
	input wire logic net_wr,
	input wire logic net_rd,
	input wire logic [31:0] net_wdata,
	output logic [31:0] net_rdata,
	// host interface register port
	input wire logic [15:0] hif_addr,
	input wire logic hif_rd,
	output logic [31:0] hif_rdata,
	// configuration memory load
	input wire logic eep_load,
	input wire logic [2:0] eep_rx_fifo_size,
	input wire logic eep_enh_link,
	// port and host state
	input wire logic hif_cfg_ok,
	input wire logic hif_wd_reloaded,
	input wire logic [3:0] port_link,
	input wire logic [3:0] port_comm,
	input wire logic [3:0] port_frame_busy,
	input wire logic [3:0] port_valid_frame,
	output logic [3:0] port_loop_closed,
	// receive path
	input wire logic rx_fifo_half_full,
	output logic rx_fwd_enable,
	output logic rx_delay_reduce,
	output logic phy_low_jitter,
	// remote link-down signalling
	input wire logic remote_link_down_req,
	output logic remote_link_down,
	// command address handling
	input wire logic cmd_valid,
	input wire logic cmd_configured,
	input wire logic [15:0] cmd_addr,
	input wire logic [15:0] station_addr,
	input wire logic [15:0] station_alias,
	output logic cmd_addr_match,
	output logic [15:0] cmd_rd_addr,
	output logic [15:0] cmd_wr_addr,
	// events and gating
	output logic net_evt_status_clr,
	output logic pdram_access_ok
);
	localparam int unsigned LD_SHORT_CYC = `DLCS_LD_SHORT_US * (`DLCS_CLK_HZ / 1000000);
	localparam int CW = 25;

	// control state
	logic [31:0] ctrl_reg, ctrl_next;
	logic [15:0] rwofs_reg, rwofs_next;
	logic first_load_reg, first_load_next;
	logic enh_link_reg, enh_link_next;
	logic [7:0] loop_save_reg, loop_save_next;
	dlcs_tmp_state_t tmp_reg, tmp_next;
	logic [CW-1:0] tmp_cnt_reg, tmp_cnt_next;
	logic [CW-1:0] ld_cnt_reg, ld_cnt_next;
	logic [3:0] loop_wr_reg, loop_wr_next;

	// output registers
	logic [31:0] net_rdata_reg, net_rdata_next;
	logic [31:0] hif_rdata_reg, hif_rdata_next;
	logic [3:0] closed_reg, closed_next;
	logic fwd_reg, fwd_next;
	logic ld_out_reg, ld_out_next;
	logic match_reg, match_next;
	logic [15:0] rd_addr_reg, rd_addr_next;
	logic [15:0] wr_addr_reg, wr_addr_next;
	logic evt_clr_reg, evt_clr_next;
	logic pdram_reg, pdram_next;

	logic [15:0] status;
	logic [3:0] loop_closed_w;
	logic ctrl_wr;

	// per-port loop controllers
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_port
			dlcs_loop_if lpi ();
			assign lpi.mode = dlcs_loop_mode_t'(ctrl_reg[`DLCS_CTRL_LOOP_LO + 2*gi +: 2]);
			assign lpi.mode_wr = loop_wr_reg[gi];
			assign lpi.link = port_link[gi];
			assign lpi.frame_busy = port_frame_busy[gi];
			assign lpi.valid_frame = port_valid_frame[gi];
			assign loop_closed_w[gi] = lpi.closed;
			dlcs_loop_port u_port (
				.ref_clk(ref_clk),
				.rst(rst),
				.lp(lpi.port)
			);
		end
	endgenerate

	assign ctrl_wr = net_wr && (net_addr == `DLCS_OFS_CTRL);

	always_comb begin
		status = 16'h0000;
		status[`DLCS_STAT_OPER] = hif_cfg_ok;
		status[`DLCS_STAT_WD] = hif_wd_reloaded;
		status[`DLCS_STAT_ENH] = enh_link_reg;
		status[`DLCS_STAT_LINK_LO +: 4] = port_link;
		for (int n = 0; n < 4; n++) begin
			status[`DLCS_STAT_PORT_LO + 2*n] = closed_reg[n];
			status[`DLCS_STAT_PORT_LO + 2*n + 1] = port_comm[n];
		end
	end

	// register file, temporary loop settings, link-down timer
	always_comb begin
		ctrl_next = ctrl_reg;
		rwofs_next = rwofs_reg;
		first_load_next = first_load_reg;
		enh_link_next = enh_link_reg;
		loop_save_next = loop_save_reg;
		tmp_next = tmp_reg;
		tmp_cnt_next = tmp_cnt_reg;
		ld_cnt_next = ld_cnt_reg;
		loop_wr_next = 4'h0;
		if (eep_load && first_load_reg) begin
			ctrl_next[`DLCS_CTRL_FIFO_HI:`DLCS_CTRL_FIFO_LO] = eep_rx_fifo_size;
			enh_link_next = eep_enh_link;
			first_load_next = 1'b0;
		end
		case (tmp_reg)
			DLCS_TMP_IDLE: begin
				tmp_cnt_next = '0;
			end
			DLCS_TMP_ACTIVE: begin
				if (tmp_cnt_reg >= CW'(TEMP_CYC - 1)) begin
					ctrl_next[`DLCS_CTRL_LOOP_HI:`DLCS_CTRL_LOOP_LO] = loop_save_reg;
					ctrl_next[`DLCS_CTRL_TEMP] = 1'b0;
					tmp_next = DLCS_TMP_IDLE;
				end else begin
					tmp_cnt_next = tmp_cnt_reg + 1'b1;
				end
			end
			default: begin
				tmp_next = DLCS_TMP_IDLE;
			end
		endcase
		if (ctrl_wr) begin
			ctrl_next = (net_wdata & `DLCS_CTRL_WMASK);
			if (first_load_reg == 1'b0 && eep_load) begin
				ctrl_next[`DLCS_CTRL_FIFO_HI:`DLCS_CTRL_FIFO_LO] = net_wdata[`DLCS_CTRL_FIFO_HI:`DLCS_CTRL_FIFO_LO];
			end
			loop_wr_next = 4'hF;
			if (net_wdata[`DLCS_CTRL_TEMP]) begin
				if (tmp_reg == DLCS_TMP_IDLE) begin
					loop_save_next = ctrl_reg[`DLCS_CTRL_LOOP_HI:`DLCS_CTRL_LOOP_LO];
				end
				tmp_next = DLCS_TMP_ACTIVE;
				tmp_cnt_next = '0;
			end else begin
				tmp_next = DLCS_TMP_IDLE;
			end
		end
		if (net_wr && (net_addr == `DLCS_OFS_RWOFS)) begin
			rwofs_next = net_wdata[15:0];
		end
		// remote link-down held for the selected time
		if (remote_link_down_req) begin
			ld_cnt_next = ctrl_reg[`DLCS_CTRL_LDTIME] ? CW'(LD_SHORT_CYC) : CW'(LD_LONG_CYC);
		end else if (ld_cnt_reg != '0) begin
			ld_cnt_next = ld_cnt_reg - 1'b1;
		end
	end

	// outputs
	always_comb begin
		net_rdata_next = 32'h0000_0000;
		hif_rdata_next = 32'h0000_0000;
		if (net_rd) begin
			case (net_addr)
				`DLCS_OFS_CTRL: net_rdata_next = ctrl_reg;
				`DLCS_OFS_RWOFS: net_rdata_next = {16'h0000, rwofs_reg};
				`DLCS_OFS_STAT: net_rdata_next = {16'h0000, status};
				default: net_rdata_next = 32'h0000_0000;
			endcase
		end
		if (hif_rd) begin
			case (hif_addr)
				`DLCS_OFS_CTRL: hif_rdata_next = ctrl_reg;
				`DLCS_OFS_RWOFS: hif_rdata_next = {16'h0000, rwofs_reg};
				`DLCS_OFS_STAT: hif_rdata_next = {16'h0000, status};
				default: hif_rdata_next = 32'h0000_0000;
			endcase
		end
		evt_clr_next = net_rd && (net_addr == `DLCS_OFS_STAT);
		closed_next = loop_closed_w;
		fwd_next = rx_fifo_half_full;
		ld_out_next = (ld_cnt_next != '0);
		match_next = 1'b0;
		if (cmd_valid && cmd_configured) begin
			match_next = (cmd_addr == station_addr) ||
				(ctrl_reg[`DLCS_CTRL_ALIAS] && (cmd_addr == station_alias));
		end
		rd_addr_next = cmd_addr;
		wr_addr_next = 16'(cmd_addr + rwofs_reg);
		pdram_next = hif_cfg_ok;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_reg <= {7'h00, 1'b0, 1'b0, 1'b0, 2'b00, 1'b0, `DLCS_FIFO_DEFAULT,
				`DLCS_LOOP_RESET, 8'h00};
			rwofs_reg <= 16'h0000;
			first_load_reg <= 1'b1;
			enh_link_reg <= 1'b0;
			loop_save_reg <= `DLCS_LOOP_RESET;
			tmp_reg <= DLCS_TMP_IDLE;
			tmp_cnt_reg <= '0;
			ld_cnt_reg <= '0;
			loop_wr_reg <= 4'h0;
			net_rdata_reg <= 32'h0000_0000;
			hif_rdata_reg <= 32'h0000_0000;
			closed_reg <= 4'hF;
			fwd_reg <= 1'b0;
			ld_out_reg <= 1'b0;
			match_reg <= 1'b0;
			rd_addr_reg <= 16'h0000;
			wr_addr_reg <= 16'h0000;
			evt_clr_reg <= 1'b0;
			pdram_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			rwofs_reg <= rwofs_next;
			first_load_reg <= first_load_next;
			enh_link_reg <= enh_link_next;
			loop_save_reg <= loop_save_next;
			tmp_reg <= tmp_next;
			tmp_cnt_reg <= tmp_cnt_next;
			ld_cnt_reg <= ld_cnt_next;
			loop_wr_reg <= loop_wr_next;
			net_rdata_reg <= net_rdata_next;
			hif_rdata_reg <= hif_rdata_next;
			closed_reg <= closed_next;
			fwd_reg <= fwd_next;
			ld_out_reg <= ld_out_next;
			match_reg <= match_next;
			rd_addr_reg <= rd_addr_next;
			wr_addr_reg <= wr_addr_next;
			evt_clr_reg <= evt_clr_next;
			pdram_reg <= pdram_next;
		end
	end

	// sizes 0 to 3 trim the receive delay
	logic delay_red_reg;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			delay_red_reg <= 1'b0;
		end else begin
			delay_red_reg <= (ctrl_next[`DLCS_CTRL_FIFO_HI:`DLCS_CTRL_FIFO_LO] <=
				`DLCS_FIFO_REDUCE_MAX);
		end
	end

	logic jitter_reg;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			jitter_reg <= 1'b0;
		end else begin
			jitter_reg <= ctrl_next[`DLCS_CTRL_JITTER];
		end
	end

	assign net_rdata = net_rdata_reg;
	assign hif_rdata = hif_rdata_reg;
	assign port_loop_closed = closed_reg;
	assign rx_fwd_enable = fwd_reg;
	assign rx_delay_reduce = delay_red_reg;
	assign phy_low_jitter = jitter_reg;
	assign remote_link_down = ld_out_reg;
	assign cmd_addr_match = match_reg;
	assign cmd_rd_addr = rd_addr_reg;
	assign cmd_wr_addr = wr_addr_reg;
	assign net_evt_status_clr = evt_clr_reg;
	assign pdram_access_ok = pdram_reg;
endmodule : dlcs_regs
`default_nettype wire

// ### dlcs_far_model.sv
// Purpose: far side of the link bank: config memory loader and port lines
// Assumes: bench sets the wanted link and frame state
// Notes: lines not held toggle so stale data shows up
`timescale 1ns/1ps
`default_nettype none
module dlcs_far_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// bench controls
	input wire logic load_req,
	input wire logic [2:0] load_size,
	input wire logic load_enh,
	input wire logic [3:0] link_set,
	input wire logic [3:0] busy_set,
	// towards the bank
	output logic eep_load,
	output logic [2:0] eep_rx_fifo_size,
	output logic eep_enh_link,
	output logic [3:0] port_link,
	output logic [3:0] port_comm,
	output logic [3:0] port_frame_busy
);
	always_ff @(posedge ref_clk) begin
		eep_load <= load_req & ~rst;
		// preset chosen by the configuring party, 7 unless clocks are tight
		eep_rx_fifo_size <= load_req ? load_size : ~eep_rx_fifo_size;
		eep_enh_link <= load_req ? load_enh : ~eep_enh_link;
		port_link <= link_set;
		// communication settles one cycle after link
		port_comm <= port_link;
		port_frame_busy <= busy_set;
	end
endmodule : dlcs_far_model
`default_nettype wire

// ### dlcs_regs_chk.sv
// Purpose: port assertions of the link register bank
// Assumes: one clock domain
// Notes: bound to the bank below
`timescale 1ns/1ps
`default_nettype none
`include "dlcs_params.svh"
module dlcs_regs_chk #(parameter int unsigned LD_LONG_CYC = 200) (
	input wire logic ref_clk, input wire logic rst,
	input wire logic [15:0] net_addr, input wire logic net_wr, input wire logic net_rd,
	input wire logic [31:0] net_wdata, input wire logic [31:0] net_rdata,
	input wire logic hif_rd, input wire logic [31:0] hif_rdata, input wire logic hif_cfg_ok,
	input wire logic rx_fifo_half_full, input wire logic rx_fwd_enable,
	input wire logic rx_delay_reduce, input wire logic phy_low_jitter,
	input wire logic remote_link_down_req, input wire logic remote_link_down,
	input wire logic cmd_valid, input wire logic cmd_configured,
	input wire logic [15:0] cmd_addr, input wire logic [15:0] station_addr,
	input wire logic [15:0] station_alias, input wire logic cmd_addr_match,
	input wire logic [15:0] cmd_rd_addr, input wire logic [15:0] cmd_wr_addr,
	input wire logic net_evt_status_clr, input wire logic pdram_access_ok
);
	logic [15:0] ofs_h;
	logic alias_h;
	logic ld_h;
	logic [31:0] hi_cnt;
	wire ctrl_wr = net_wr && net_addr == `DLCS_OFS_CTRL;
	wire [15:0] wr_now = cmd_addr + ofs_h;
	wire match_now = cmd_configured && (cmd_addr == station_addr ||
		(alias_h && cmd_addr == station_alias));
	wire mapped = net_addr == `DLCS_OFS_CTRL || net_addr == `DLCS_OFS_RWOFS ||
		net_addr == `DLCS_OFS_STAT;
	// mirror of the writable bits the assertions need, and high-time counter of remote_link_down
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ofs_h <= 16'h0000;
			alias_h <= 1'b0;
			ld_h <= 1'b0;
			hi_cnt <= 32'h00000000;
		end else begin
			if (net_wr && net_addr == `DLCS_OFS_RWOFS)
				ofs_h <= net_wdata[15:0];
			if (ctrl_wr)
				alias_h <= net_wdata[`DLCS_CTRL_ALIAS];
			if (ctrl_wr)
				ld_h <= net_wdata[`DLCS_CTRL_LDTIME];
			hi_cnt <= remote_link_down_req ? 32'h00000000 : hi_cnt + remote_link_down;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_fwd_follow: assert property (!$past(rst) |-> rx_fwd_enable == $past(rx_fifo_half_full))
		else $error("forwarding enable does not follow fifo level");
	chk_fifo_reduce: assert property (ctrl_wr |-> ##2 rx_delay_reduce == ($past(net_wdata[18:16], 2) <= 3'h3))
		else $error("receive delay reduction wrong for fifo size");
	chk_jitter_bit: assert property (ctrl_wr |-> ##2 phy_low_jitter == $past(net_wdata[19], 2))
		else $error("low jitter output does not follow control bit");
	chk_alias_match: assert property (cmd_valid |=> cmd_addr_match == $past(match_now))
		else $error("address match wrong");
	chk_rw_addr: assert property (!$past(rst) |-> cmd_wr_addr == $past(wr_now) && cmd_rd_addr == $past(cmd_addr))
		else $error("read or write address wrong");
	chk_evt_clear: assert property (!$past(rst) |-> net_evt_status_clr == $past(net_rd && net_addr == `DLCS_OFS_STAT))
		else $error("event clear not tied to network status read");
	chk_pdram_gate: assert property (!$past(rst) |-> pdram_access_ok == $past(hif_cfg_ok))
		else $error("process ram gate wrong");
	chk_idle_zero: assert property (!(net_rd && mapped) && !hif_rd |=> net_rdata == 32'h00000000)
		else $error("read data not zero when idle or unmapped");
	chk_ld_start: assert property (remote_link_down_req |=> remote_link_down)
		else $error("link down signalling did not start");
	chk_ld_length: assert property ($fell(remote_link_down) |-> hi_cnt == (ld_h ? 32'h00000640 : LD_LONG_CYC))
		else $error("link down signalling length wrong");
	cover property (ctrl_wr);
	cover property (net_evt_status_clr);
	cover property ($fell(remote_link_down));
endmodule : dlcs_regs_chk
bind dlcs_regs dlcs_regs_chk #(.LD_LONG_CYC(LD_LONG_CYC)) i_chk (.*);
`default_nettype wire

// ### testbench.sv
// Purpose: self-checking bench of the link register bank
// Assumes: inputs change at the falling edge
// Notes: long timers shortened by parameters
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dlcs_pkg::*;
	localparam int unsigned LD_CYC = 200;
	localparam int unsigned TMP_CYC = 300;
	typedef struct packed {logic [15:0] a; logic [31:0] d; logic [31:0] e;} dlcs_row_t;
	logic ref_clk = 1'b0, rst = 1'b1, net_wr = 1'b0, net_rd = 1'b0, hif_rd = 1'b0;
	logic [15:0] net_addr = 16'h0000, hif_addr = 16'h0000, cmd_addr = 16'h0000;
	logic [15:0] station_addr = 16'h1001, station_alias = 16'h2002, cmd_rd_addr, cmd_wr_addr;
	logic [31:0] net_wdata = 32'h00000000, net_rdata, hif_rdata, rd;
	logic load_req = 1'b0, load_enh = 1'b0, eep_load, eep_enh_link;
	logic [2:0] load_size = 3'h7, eep_rx_fifo_size;
	logic hif_cfg_ok = 1'b0, hif_wd_reloaded = 1'b0, rx_fifo_half_full = 1'b0;
	logic remote_link_down_req = 1'b0, cmd_valid = 1'b0, cmd_configured = 1'b0;
	logic [3:0] link_set = 4'h0, busy_set = 4'h0, port_valid_frame = 4'h0;
	logic [3:0] port_link, port_comm, port_frame_busy, port_loop_closed;
	logic rx_fwd_enable, rx_delay_reduce, phy_low_jitter, remote_link_down;
	logic cmd_addr_match, net_evt_status_clr, pdram_access_ok;
	int error_cnt = 0, n_compared = 0, n;
	dlcs_row_t rows [5] = '{'{16'h0100, 32'hFFFFFFFF, 32'h014FFF02},
		'{16'h0100, 32'h00480000, 32'h00480000}, '{16'h0108, 32'hFFFF1234, 32'h00001234},
		'{16'h0104, 32'hFFFFFFFF, 32'h00000000}, '{16'h0110, 32'h0000AAAA, 32'h00005500}};
	dlcs_regs #(.LD_LONG_CYC(LD_CYC), .TEMP_CYC(TMP_CYC)) i_dut (.*);
	dlcs_far_model i_far (.*);
	always #25 ref_clk = ~ref_clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk);
	endtask : cyc
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		cyc(1);
		net_addr = a;
		net_wdata = d;
		net_wr = 1'b1;
		cyc(1);
		net_wr = 1'b0;
	endtask : wr
	task automatic rdr(input logic host, input logic [15:0] a);
		cyc(1);
		net_addr = a;
		hif_addr = a;
		net_rd = ~host;
		hif_rd = host;
		cyc(1);
		net_rd = 1'b0;
		hif_rd = 1'b0;
		rd = host ? hif_rdata : net_rdata;
	endtask : rdr
	task automatic final_report;
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	// watchdog: all tests need about 2300 cycles
	initial begin
		repeat (12000) @(posedge ref_clk);
		error_cnt++;
		final_report();
	end
	initial begin
		cyc(2);
		rst = 1'b0;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rdr(1'b0, rows[i].a);
			check(rd, rows[i].e);
			rdr(1'b1, rows[i].a);
			check(rd, rows[i].e);
		end
		$display("register table test done");
		cmd_addr = 16'hF000;
		cyc(2);
		check(cmd_wr_addr, 32'h00000234);
		check(cmd_rd_addr, 32'h0000F000);
		cmd_valid = 1'b1;
		cmd_configured = 1'b1;
		cmd_addr = station_alias;
		cyc(2);
		check(cmd_addr_match, 32'h0);
		wr(16'h0100, 32'h01480000);
		cyc(2);
		check(cmd_addr_match, 32'h1);
		cmd_configured = 1'b0;
		cyc(2);
		check(cmd_addr_match, 32'h0);
		for (int k = 0; k < 2; k++) begin
			wr(16'h0100, k ? 32'h00080000 : 32'h00480000);
			cyc(1);
			remote_link_down_req = 1'b1;
			cyc(1);
			remote_link_down_req = 1'b0;
			n = 0;
			while (remote_link_down === 1'b1 && n < 3000) begin
				cyc(1);
				n++;
			end
			check(n, k ? LD_CYC : 1600);
		end
		check(phy_low_jitter, 32'h1);
		for (int s = 0; s < 8; s++) begin
			wr(16'h0100, {13'h0000, s[2:0], 16'h0000});
			cyc(2);
			check(rx_delay_reduce, s < 4);
		end
		$display("control bit test done");
		hif_cfg_ok = 1'b1;
		hif_wd_reloaded = 1'b1;
		rx_fifo_half_full = 1'b1;
		busy_set = 4'hF;
		link_set = 4'h5;
		cyc(8);
		check(rx_fwd_enable, 32'h1);
		check(pdram_access_ok, 32'h1);
		check(port_loop_closed, 32'hF);
		busy_set = 4'h0;
		cyc(6);
		check(port_loop_closed, 32'hA);
		rdr(1'b0, 16'h0110);
		check(rd, 32'h00006653);
		check(net_evt_status_clr, 32'h1);
		hif_wd_reloaded = 1'b0;
		cyc(3);
		rdr(1'b1, 16'h0110);
		check(rd, 32'h00006651);
		check(net_evt_status_clr, 32'h0);
		link_set = 4'h0;
		cyc(4);
		wr(16'h0100, 32'h00074E00);
		cyc(6);
		check(port_loop_closed, 32'hE);
		// auto-close stays shut on link up until a valid frame
		link_set = 4'h8;
		cyc(4);
		check(port_loop_closed, 32'hE);
		port_valid_frame = 4'h8;
		cyc(1);
		port_valid_frame = 4'h0;
		cyc(4);
		check(port_loop_closed, 32'h6);
		link_set = 4'h0;
		cyc(4);
		wr(16'h0100, 32'h0007AA02);
		cyc(6);
		check(port_loop_closed, 32'h0);
		cyc(TMP_CYC + 10);
		rdr(1'b0, 16'h0100);
		check(rd, 32'h00074E00);
		$display("loop and status test done");
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		check(port_loop_closed, 32'hF);
		rdr(1'b0, 16'h0100);
		check(rd, 32'h00070000);
		rdr(1'b1, 16'h0108);
		check(rd, 32'h00000000);
		for (int k = 0; k < 2; k++) begin
			load_size = k ? 3'h5 : 3'h2;
			load_enh = ~k[0];
			load_req = 1'b1;
			cyc(1);
			load_req = 1'b0;
			cyc(4);
		end
		check(rx_delay_reduce, 32'h1);
		rdr(1'b0, 16'h0100);
		check(rd, 32'h00020000);
		rdr(1'b1, 16'h0110);
		check(rd, 32'h00005505);
		$display("reset and load test done");
		final_report();
	end
endmodule : testbench
`default_nettype wire
